//--- include/arc_consts.svh
// Purpose: Offsets, field positions, reset values and masks of the reference control bank.
// Assumes: Eight-bit register port; byte offsets as seen by software.
// Notes: Definitions only.
// Functional notes
// - High offset register returns offset bits 9:2.
// - Low register: offset bits 1:0, rest zero.
// - Offset value is per-part, captured from fuses.
// - Source select 00 ext, 01 supply, 10 digital, 11 fast.
// - Bit 5 picks ground pin or analog ground pin.
// - Bit 2 enables the temperature sensor.
// - Disabled sensor output is high impedance.
// - Fast reference follows converter demand automatically.
// - Analog ground used in tracking and conversion.
// - Sensor sampling always uses internal chip ground.
// - Fast reference conversion uses internal chip ground.
// - Control bits 7:6 and 1:0 read zero.
`ifndef ARC_CONSTS_SVH
`define ARC_CONSTS_SVH

// ============================================================
// Register offsets
`define ARC_OFF_OFFSET_LOW 8'h85
`define ARC_OFF_OFFSET_HIGH 8'h86
`define ARC_OFF_REF_CTRL 8'hd1

// ============================================================
// Field positions
`define ARC_GND_BIT 5
`define ARC_VREF_MSB 4
`define ARC_VREF_LSB 3
`define ARC_SENS_BIT 2
`define ARC_CAL_HIGH_MSB 9
`define ARC_CAL_HIGH_LSB 2
`define ARC_CAL_LOW_MSB 1
`define ARC_CAL_LOW_LSB 0

// ============================================================
// Reset values and masks
`define ARC_REF_CTRL_RESET 8'h18
`define ARC_REF_CTRL_WMASK 8'h3c
`define ARC_CAL_RESET 10'h000
`define ARC_READ_IDLE 8'h00

`endif

//--- include/arc_pkg.sv
// Purpose: Types shared by the reference control bank.
// Assumes: Nothing beyond the constants header.
// Notes: No constants live here.
package arc_pkg;

    // ============================================================
    // Voltage reference sources
    typedef enum logic [1:0] {
        ARC_VREF_EXT_PIN = 2'b00,
        ARC_VREF_SUPPLY = 2'b01,
        ARC_VREF_DIGITAL = 2'b10,
        ARC_VREF_FAST = 2'b11
    } arc_vref_e;

    // ============================================================
    // Calibration capture states
    typedef enum logic [0:0] {
        ARC_CAP_WAIT = 1'b0,
        ARC_CAP_HELD = 1'b1
    } arc_cap_e;

endpackage

//--- core/arc_ground_mux.sv
// Purpose: Chooses the converter ground reference from the select bit and the phase.
// Assumes: Phase and input flags come from converter logic on the same clock.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module arc_ground_mux (
    // Configuration
    input wire logic ground_ref_sel,
    input wire logic fast_ref_selected,
    // Converter phase
    input wire logic tracking,
    input wire logic converting,
    input wire logic temp_selected,
    // Result
    output logic use_analog_ground
);

    // ============================================================
    // Ground choice
    always_comb begin
        use_analog_ground = ground_ref_sel;
        if (tracking && temp_selected) begin
            use_analog_ground = 1'b0;
        end
        if (converting && fast_ref_selected) begin
            use_analog_ground = 1'b0;
        end
    end

endmodule

//--- core/arc_regs.sv
// Purpose: Reference control and sensor offset registers of the converter unit.
// Assumes: Register master and converter logic share this clock.
// Notes: Offset value is taken from fuse outputs once after reset release.
`timescale 1ns/1ps
`include "arc_consts.svh"
module arc_regs #(
    parameter int ADDR_WIDTH = 8,
    parameter int CAL_WIDTH = 10
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Per-part calibration fuses
    input wire logic [CAL_WIDTH-1:0] cal_fuse_value,
    // Converter activity
    input wire logic conv_demand,
    input wire logic conv_tracking,
    input wire logic conv_converting,
    input wire logic conv_temp_selected,
    // Analog controls
    output logic [1:0] vref_source_sel,
    output logic fast_ref_enable,
    output logic ground_use_analog,
    output logic sensor_enable_bit,
    output logic sensor_output_hiz
);

    // ============================================================
    // Elaboration checks
    if (CAL_WIDTH != 10) begin : g_bad_cal
        $error("arc_regs: offset value must be ten bits wide");
    end
    if (ADDR_WIDTH < 8) begin : g_bad_addr
        $error("arc_regs: address must be at least eight bits wide");
    end

    // ============================================================
    // Declarations
    localparam logic [ADDR_WIDTH-1:0] OffLow = ADDR_WIDTH'(`ARC_OFF_OFFSET_LOW);
    localparam logic [ADDR_WIDTH-1:0] OffHigh = ADDR_WIDTH'(`ARC_OFF_OFFSET_HIGH);
    localparam logic [ADDR_WIDTH-1:0] OffCtrl = ADDR_WIDTH'(`ARC_OFF_REF_CTRL);

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [CAL_WIDTH-1:0] cal_q;
    logic [CAL_WIDTH-1:0] cal_d;
    arc_pkg::arc_cap_e cap_q;
    arc_pkg::arc_cap_e cap_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic fast_q;
    logic fast_d;
    logic analog_ground_pin_q;
    logic analog_ground_pin_d;
    logic hiz_q;
    logic hiz_d;
    logic fast_selected;
    logic analog_ground_pin_choice;

    // ============================================================
    // Calibration capture
    always_comb begin
        cap_d = cap_q;
        cal_d = cal_q;
        case (cap_q)
            arc_pkg::ARC_CAP_WAIT: begin
                cal_d = cal_fuse_value;
                cap_d = arc_pkg::ARC_CAP_HELD;
            end
            arc_pkg::ARC_CAP_HELD: begin
                cal_d = cal_q;
            end
            default: begin
                cap_d = arc_pkg::ARC_CAP_WAIT;
            end
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cap_q <= arc_pkg::ARC_CAP_WAIT;
            cal_q <= `ARC_CAL_RESET;
        end else begin
            cap_q <= cap_d;
            cal_q <= cal_d;
        end
    end

    // ============================================================
    // Control register
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr && reg_addr == OffCtrl) begin
            ctrl_d = reg_wdata & `ARC_REF_CTRL_WMASK;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl_q <= `ARC_REF_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ============================================================
    // Read path
    always_comb begin
        rdata_d = `ARC_READ_IDLE;
        if (reg_rd) begin
            case (reg_addr)
                OffHigh: begin
                    rdata_d = cal_q[`ARC_CAL_HIGH_MSB:`ARC_CAL_HIGH_LSB];
                end
                OffLow: begin
                    rdata_d = {cal_q[`ARC_CAL_LOW_MSB:`ARC_CAL_LOW_LSB], 6'h00};
                end
                OffCtrl: begin
                    rdata_d = ctrl_q & `ARC_REF_CTRL_WMASK;
                end
                default: begin
                    rdata_d = `ARC_READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rdata_q <= `ARC_READ_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ============================================================
    // Analog control outputs
    assign fast_selected = ctrl_q[`ARC_VREF_MSB:`ARC_VREF_LSB] == arc_pkg::ARC_VREF_FAST;

    arc_ground_mux u_ground_mux (
        .ground_ref_sel(ctrl_q[`ARC_GND_BIT]),
        .fast_ref_selected(fast_selected),
        .tracking(conv_tracking),
        .converting(conv_converting),
        .temp_selected(conv_temp_selected),
        .use_analog_ground(analog_ground_pin_choice)
    );

    always_comb begin
        fast_d = fast_selected && conv_demand;
        analog_ground_pin_d = analog_ground_pin_choice;
        hiz_d = !ctrl_d[`ARC_SENS_BIT];
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fast_q <= 1'b0;
            analog_ground_pin_q <= 1'b0;
            hiz_q <= 1'b1;
        end else begin
            fast_q <= fast_d;
            analog_ground_pin_q <= analog_ground_pin_d;
            hiz_q <= hiz_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign vref_source_sel = ctrl_q[`ARC_VREF_MSB:`ARC_VREF_LSB];
    assign sensor_enable_bit = ctrl_q[`ARC_SENS_BIT];
    assign sensor_output_hiz = hiz_q;
    assign fast_ref_enable = fast_q;
    assign ground_use_analog = analog_ground_pin_q;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    read_high_a: assert property (
        reg_rd && reg_addr == OffHigh && cap_q == arc_pkg::ARC_CAP_HELD
        |=> reg_rdata == cal_q[9:2])
        else $error("high offset read returned wrong bits");

    read_low_a: assert property (
        reg_rd && reg_addr == OffLow && cap_q == arc_pkg::ARC_CAP_HELD
        |=> reg_rdata == {cal_q[1:0], 6'h00})
        else $error("low offset read returned wrong bits");

    low_unused_a: assert property (
        reg_rd && reg_addr == OffLow |=> reg_rdata[5:0] == 6'h00)
        else $error("low offset unused bits not zero");

    cal_capture_a: assert property (
        cap_q == arc_pkg::ARC_CAP_WAIT ##1 cap_q == arc_pkg::ARC_CAP_HELD
        |-> cal_q == $past(cal_fuse_value)
        ##1 (cal_q == $past(cal_q)) [*3])
        else $error("offset value not captured or not held");

    vref_write_a: assert property (
        reg_wr && reg_addr == OffCtrl |=> vref_source_sel == $past(reg_wdata[4:3]))
        else $error("source select did not follow write");

    gnd_select_a: assert property (
        !conv_tracking && !conv_converting |=> ground_use_analog == $past(ctrl_q[5]))
        else $error("ground choice did not follow select bit");

    sensor_hiz_a: assert property (
        sensor_enable_bit != sensor_output_hiz)
        else $error("sensor enable and high impedance disagree");

    fast_auto_a: assert property (
        fast_selected && conv_demand |=> fast_ref_enable)
        else $error("fast reference not enabled on demand");

    fast_off_a: assert property (
        !(fast_selected && conv_demand) |=> !fast_ref_enable)
        else $error("fast reference enabled without demand");

    analog_ground_pin_track_a: assert property (
        ctrl_q[5] && conv_tracking && !conv_temp_selected && !conv_converting
        |=> ground_use_analog)
        else $error("analog ground not used while tracking");

    temp_ground_a: assert property (
        conv_tracking && conv_temp_selected |=> !ground_use_analog)
        else $error("sensor sampling did not use chip ground");

    fast_ground_a: assert property (
        conv_converting && fast_selected |=> !ground_use_analog)
        else $error("fast reference conversion did not use chip ground");

    ctrl_unused_a: assert property (
        reg_rd && reg_addr == OffCtrl |=> reg_rdata[7:6] == 2'b00 && reg_rdata[1:0] == 2'b00)
        else $error("control unused bits not zero");

    reset_value_a: assert property (@(posedge clock) disable iff (1'b0)
        $fell(reset) |-> vref_source_sel == 2'b11 && !ground_use_analog
        && !sensor_enable_bit && ctrl_q == 8'h18)
        else $error("control register reset value wrong");

    read_idle_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stood outside answer cycle");

    ctrl_write_c: cover property (reg_wr && reg_addr == OffCtrl ##1 reg_rd && reg_addr == OffCtrl);
    fast_demand_c: cover property (fast_selected && conv_demand ##1 fast_ref_enable);
    temp_track_c: cover property (ctrl_q[5] && conv_tracking && conv_temp_selected);
    offset_read_c: cover property (reg_rd && reg_addr == OffHigh ##1 reg_rd && reg_addr == OffLow);

endmodule

//--- test/arc_regs_tb.sv
// Purpose: Self-checking bench for the reference control and sensor offset registers.
// Assumes: Register port reads answer in the cycle after the read strobe.
// Notes: Offset fuses are held at a fixed value, then changed after capture.
`timescale 1ns/1ps
`include "arc_consts.svh"
module testbench;

    // ============================================================
    // Signals
    logic clock;
    logic reset;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [9:0] cal_fuse_value;
    logic conv_demand;
    logic conv_tracking;
    logic conv_converting;
    logic conv_temp_selected;
    logic [1:0] vref_source_sel;
    logic fast_ref_enable;
    logic ground_use_analog;
    logic sensor_enable_bit;
    logic sensor_output_hiz;
    int n_fail;
    int samples_checked;

    arc_regs dut_u (
        .clock(clock),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .cal_fuse_value(cal_fuse_value),
        .conv_demand(conv_demand),
        .conv_tracking(conv_tracking),
        .conv_converting(conv_converting),
        .conv_temp_selected(conv_temp_selected),
        .vref_source_sel(vref_source_sel),
        .fast_ref_enable(fast_ref_enable),
        .ground_use_analog(ground_use_analog),
        .sensor_enable_bit(sensor_enable_bit),
        .sensor_output_hiz(sensor_output_hiz)
    );

    always #4 clock = ~clock;

    // ============================================================
    // Helpers
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic conv(input logic dm, input logic tr, input logic cv, input logic tp);
        @(posedge clock);
        conv_demand <= dm;
        conv_tracking <= tr;
        conv_converting <= cv;
        conv_temp_selected <= tp;
        step(2);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        chk({6'h00, vref_source_sel}, 8'h03);
        chk({7'h00, sensor_enable_bit}, 8'h00);
        chk({7'h00, sensor_output_hiz}, 8'h01);
        chk({7'h00, fast_ref_enable}, 8'h00);
        rd(`ARC_OFF_REF_CTRL, 8'h18);
    endtask

    task automatic t_offset();
        rd(`ARC_OFF_OFFSET_HIGH, 8'had);
        rd(`ARC_OFF_OFFSET_LOW, 8'h40);
        wr(`ARC_OFF_OFFSET_HIGH, 8'h00);
        wr(`ARC_OFF_OFFSET_LOW, 8'hff);
        cal_fuse_value <= 10'h0f3;
        rd(`ARC_OFF_OFFSET_HIGH, 8'had);
        rd(`ARC_OFF_OFFSET_LOW, 8'h40);
        rd(8'h00, 8'h00);
    endtask

    task automatic t_ctrl();
        wr(`ARC_OFF_REF_CTRL, 8'hff);
        rd(`ARC_OFF_REF_CTRL, 8'h3c);
        chk({7'h00, sensor_enable_bit}, 8'h01);
        chk({7'h00, sensor_output_hiz}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`ARC_OFF_REF_CTRL, 8'(i << 3));
            step(1);
            chk({6'h00, vref_source_sel}, 8'(i));
        end
        chk({7'h00, sensor_enable_bit}, 8'h00);
        chk({7'h00, sensor_output_hiz}, 8'h01);
    endtask

    task automatic t_fast();
        wr(`ARC_OFF_REF_CTRL, 8'h18);
        conv(1'b1, 1'b0, 1'b1, 1'b0);
        chk({7'h00, fast_ref_enable}, 8'h01);
        conv(1'b0, 1'b0, 1'b0, 1'b0);
        chk({7'h00, fast_ref_enable}, 8'h00);
        wr(`ARC_OFF_REF_CTRL, 8'h08);
        conv(1'b1, 1'b0, 1'b1, 1'b0);
        chk({7'h00, fast_ref_enable}, 8'h00);
    endtask

    task automatic t_ground();
        wr(`ARC_OFF_REF_CTRL, 8'h20);
        conv(1'b0, 1'b1, 1'b0, 1'b0);
        chk({7'h00, ground_use_analog}, 8'h01);
        conv(1'b0, 1'b0, 1'b1, 1'b0);
        chk({7'h00, ground_use_analog}, 8'h01);
        conv(1'b0, 1'b1, 1'b0, 1'b1);
        chk({7'h00, ground_use_analog}, 8'h00);
        wr(`ARC_OFF_REF_CTRL, 8'h38);
        conv(1'b1, 1'b0, 1'b1, 1'b0);
        chk({7'h00, ground_use_analog}, 8'h00);
        conv(1'b0, 1'b1, 1'b0, 1'b0);
        chk({7'h00, ground_use_analog}, 8'h01);
        wr(`ARC_OFF_REF_CTRL, 8'h00);
        conv(1'b0, 1'b1, 1'b0, 1'b0);
        chk({7'h00, ground_use_analog}, 8'h00);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cal_fuse_value = 10'h2b5;
        conv_demand = 1'b0;
        conv_tracking = 1'b0;
        conv_converting = 1'b0;
        conv_temp_selected = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        step(2);
        t_reset();
        t_offset();
        t_ctrl();
        t_fast();
        t_ground();
        results();
    end

    initial begin
        #20000;
        n_fail = n_fail + 1;
        results();
    end

endmodule
